// File: pptr_pkg.sv
/*
  package of the power ping and tone relay: register map, field positions,
  reset values, ping width windows and tone lengths.
  assumes a 200 MHz system clock; all counts are in system clock cycles.
*/
package pptr_pkg;
  // ---------------------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_DEVICE_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CHAIN_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_GPIO_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_INT_MASK = 8'h14;
  localparam logic [7:0] ADDR_ADC_CHANNEL = 8'h18;
  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int DCFG_MULTIDROP_BIT = 0;
  localparam int CTL_EMIT_WAKE_BIT = 0;
  localparam int CTL_EMIT_SLEEP_EXIT_BIT = 1;
  localparam int CTL_FAULT_BIT = 2;
  localparam int GCFG_SPI_BIT = 16;
  // interrupt status bits: wake, shutdown, sleep exit, hard reset, tone sent
  localparam int EV_WIDTH = 5;
  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [31:0] RST_DEVICE_CONFIG = 32'h0000_0000;
  // two bits per pin, 2'b00 means input with weak pulldown
  localparam logic [15:0] RST_GPIO_MODE = 16'h0000;
  localparam logic [EV_WIDTH-1:0] RST_INT_MASK = 5'h00;
  // ---------------------------------------------------------------------------
  // ping low-phase windows and tone lengths (plain defaults)
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int WAKE_MIN_US = 2000;
  localparam int SLEEP_EXIT_MIN_US = 200;
  localparam int SHUTDOWN_MIN_US = 7000;
  localparam int HARD_RESET_MIN_US = 36000;
  localparam int PING_MIN_US = 100;
  localparam int SLEEP_EXIT_MIN_CYC = SLEEP_EXIT_MIN_US * CLK_MHZ;
  localparam int WAKE_MIN_CYC = WAKE_MIN_US * CLK_MHZ;
  localparam int SHUTDOWN_MIN_CYC = SHUTDOWN_MIN_US * CLK_MHZ;
  localparam int HARD_RESET_MIN_CYC = HARD_RESET_MIN_US * CLK_MHZ;
  localparam int PING_MIN_CYC = PING_MIN_US * CLK_MHZ;
  localparam int COUPLET_CYC = 200;
  localparam int WAKE_COUPLETS = 8;
  localparam int SLEEP_EXIT_COUPLETS = 4;
  localparam int ADC_CHANNELS = 9;
  localparam int ADC_SLOT_CYC = 64;
  typedef enum logic [2:0] {
    PT_NONE, PT_WAKE, PT_SHUTDOWN, PT_SLEEP_EXIT, PT_HARD_RESET
  } pptr_ping_t;
endpackage

// File: pptr_top.sv
/*
  power ping and tone relay: decodes host pings on the uart receive line,
  relays wake and sleep exit tones up the chain, detects tones from below,
  and holds the transmit pin, fault output, gpio modes and adc round robin.
  assumes a single 200 MHz clock, synchronous reset, and a register master
  that keeps strobes one cycle long and never both at once.
*/
`timescale 1ns/10ps
module pptr_top
  import pptr_pkg::*;
#(
  parameter int SLEEP_EXIT_MIN = SLEEP_EXIT_MIN_CYC,
  parameter int WAKE_MIN = WAKE_MIN_CYC,
  parameter int SHUTDOWN_MIN = SHUTDOWN_MIN_CYC,
  parameter int HARD_RESET_MIN = HARD_RESET_MIN_CYC,
  parameter int PING_MIN = PING_MIN_CYC,
  parameter int WAKE_TONE_LEN = WAKE_COUPLETS,
  parameter int SLEEP_EXIT_TONE_LEN = SLEEP_EXIT_COUPLETS
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [31:0] reg_rdata_o,
  // uart pins
  input wire logic uart_rx_i,
  output logic uart_tx_o,
  output logic uart_tx_oe_o,
  input wire logic uart_tx_data_i,
  input wire logic powered_down_i,
  // chain ports, couplet level on each
  input wire logic lower_chain_port_i,
  output logic upper_chain_port_o,
  output logic upper_chain_port_oe_o,
  output logic lower_chain_port_oe_o,
  // fault
  input wire logic fault_event_i,
  output logic fault_out_n_o,
  output logic fault_out_n_oe_o,
  // gpio mode and adc selection
  output logic [15:0] gpio_mode_o,
  output logic spi_select_o,
  output logic [3:0] adc_channel_o,
  // decoded requests to the power manager
  output logic wake_request_o,
  output logic shutdown_request_o,
  output logic sleep_exit_request_o,
  output logic hard_reset_request_o,
  output logic is_stack_o,
  output logic irq_o
);
  // ---------------------------------------------------------------------------
  // pin synchronisers: three flops, change counts when second and third agree
  // ---------------------------------------------------------------------------
  logic [2:0] rx_sync_q;
  logic [2:0] chain_sync_q;
  logic rx_q;
  logic chain_q;
  // sync chains
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_sync_q <= 3'h7;
      chain_sync_q <= 3'h0;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], uart_rx_i};
      chain_sync_q <= {chain_sync_q[1:0], lower_chain_port_i};
    end
  end
  // filtered levels
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_q <= 1'b1;
      chain_q <= 1'b0;
    end else begin
      if (rx_sync_q[1] == rx_sync_q[2]) begin
        rx_q <= rx_sync_q[2];
      end
      if (chain_sync_q[1] == chain_sync_q[2]) begin
        chain_q <= chain_sync_q[2];
      end
    end
  end
  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic multidrop_q; // multidrop enable
  logic fault_ctl_q; // software fault force
  logic [15:0] gpio_mode_q; // two bits per pin
  logic spi_q; // spi on gpio 7 to 4
  logic [EV_WIDTH-1:0] int_status_q;
  logic [EV_WIDTH-1:0] int_mask_q;
  logic is_stack_q; // woken by tone
  logic [31:0] rdata_q;
  // decodes
  wire wr_dcfg = reg_write_i && (reg_addr_i == ADDR_DEVICE_CONFIG);
  wire wr_ctl = reg_write_i && (reg_addr_i == ADDR_CHAIN_CONTROL);
  wire wr_gcfg = reg_write_i && (reg_addr_i == ADDR_GPIO_CONFIG);
  wire wr_ists = reg_write_i && (reg_addr_i == ADDR_INT_STATUS);
  wire wr_imsk = reg_write_i && (reg_addr_i == ADDR_INT_MASK);
  wire emit_wake = wr_ctl && reg_wdata_i[CTL_EMIT_WAKE_BIT];
  wire emit_sleep_exit_tone = wr_ctl && reg_wdata_i[CTL_EMIT_SLEEP_EXIT_BIT];
  // ---------------------------------------------------------------------------
  // ping decoder: measure low phase, classify on rising edge
  // ---------------------------------------------------------------------------
  logic [31:0] low_cnt_q;
  logic rx_prev_q;
  pptr_ping_t ping_q;
  wire rx_rise = rx_q && !rx_prev_q;
  pptr_ping_t ping_class;
  always_comb begin
    ping_class = PT_NONE;
    if (low_cnt_q >= 32'(HARD_RESET_MIN)) begin
      ping_class = PT_HARD_RESET;
    end else if (low_cnt_q >= 32'(SHUTDOWN_MIN)) begin
      ping_class = PT_SHUTDOWN;
    end else if (low_cnt_q >= 32'(WAKE_MIN)) begin
      ping_class = PT_WAKE;
    end else if (low_cnt_q >= 32'(SLEEP_EXIT_MIN)) begin
      ping_class = PT_SLEEP_EXIT;
    end
  end
  // low-phase counter, saturating
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      low_cnt_q <= 32'h0000_0000;
      rx_prev_q <= 1'b1;
      ping_q <= PT_NONE;
    end else begin
      rx_prev_q <= rx_q;
      ping_q <= rx_rise ? ping_class : PT_NONE;
      if (rx_q) begin
        low_cnt_q <= 32'h0000_0000;
      end else if (low_cnt_q != 32'hFFFF_FFFF) begin
        low_cnt_q <= low_cnt_q + 32'h0000_0001;
      end
    end
  end
  // ---------------------------------------------------------------------------
  // tone detector on the lower chain port: count couplet edges in a burst
  // ---------------------------------------------------------------------------
  logic chain_prev_q;
  logic [7:0] edge_cnt_q;
  logic [15:0] quiet_cnt_q;
  logic tone_wake_q;
  logic tone_sleep_exit_q;
  wire chain_edge = chain_q != chain_prev_q;
  wire burst_end = (quiet_cnt_q == 16'(4 * COUPLET_CYC)) && (edge_cnt_q != 8'h00);
  wire [7:0] couplets = {1'b0, edge_cnt_q[7:1]};
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      chain_prev_q <= 1'b0;
      edge_cnt_q <= 8'h00;
      quiet_cnt_q <= 16'h0000;
      tone_wake_q <= 1'b0;
      tone_sleep_exit_q <= 1'b0;
    end else begin
      chain_prev_q <= chain_q;
      tone_wake_q <= burst_end && !multidrop_q && (couplets >= 8'(WAKE_TONE_LEN));
      tone_sleep_exit_q <= burst_end && !multidrop_q && (couplets >= 8'(SLEEP_EXIT_TONE_LEN))
                           && (couplets < 8'(WAKE_TONE_LEN));
      if (chain_edge) begin
        quiet_cnt_q <= 16'h0000;
        edge_cnt_q <= (edge_cnt_q == 8'hFF) ? edge_cnt_q : edge_cnt_q + 8'h01;
      end else if (burst_end) begin
        edge_cnt_q <= 8'h00;
        quiet_cnt_q <= 16'h0000;
      end else if (edge_cnt_q != 8'h00) begin
        quiet_cnt_q <= quiet_cnt_q + 16'h0001;
      end
    end
  end
  // ---------------------------------------------------------------------------
  // tone generator on the upper chain port
  // ---------------------------------------------------------------------------
  logic [7:0] tone_left_q; // half couplets remaining
  logic [15:0] half_cnt_q;
  logic tone_level_q;
  logic tone_done_q;
  // only wake and sleep exit start a tone
  wire relay_wake = ping_q == PT_WAKE || tone_wake_q;
  wire relay_sleep = ping_q == PT_SLEEP_EXIT || tone_sleep_exit_q;
  wire start_wake = (relay_wake || emit_wake) && !multidrop_q;
  wire start_sleep = (relay_sleep || emit_sleep_exit_tone) && !multidrop_q;
  wire tone_busy = tone_left_q != 8'h00;
  // burst timing
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tone_left_q <= 8'h00;
      half_cnt_q <= 16'h0000;
      tone_level_q <= 1'b0;
      tone_done_q <= 1'b0;
    end else begin
      tone_done_q <= 1'b0;
      if (!tone_busy && start_wake) begin
        tone_left_q <= 8'(2 * WAKE_TONE_LEN);
        half_cnt_q <= 16'h0000;
      end else if (!tone_busy && start_sleep) begin
        tone_left_q <= 8'(2 * SLEEP_EXIT_TONE_LEN);
        half_cnt_q <= 16'h0000;
      end else if (tone_busy) begin
        if (half_cnt_q == 16'(COUPLET_CYC / 2 - 1)) begin
          half_cnt_q <= 16'h0000;
          tone_level_q <= !tone_level_q;
          tone_left_q <= tone_left_q - 8'h01;
          tone_done_q <= tone_left_q == 8'h01;
        end else begin
          half_cnt_q <= half_cnt_q + 16'h0001;
        end
      end
    end
  end
  // ---------------------------------------------------------------------------
  // requests, stack detection, events
  // ---------------------------------------------------------------------------
  logic wake_req_q;
  logic shut_req_q;
  logic sleep_req_q;
  logic hard_req_q;
  wire [EV_WIDTH-1:0] events = {tone_done_q, hard_req_q, sleep_req_q, shut_req_q, wake_req_q};
  // shutdown and reset act locally only
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wake_req_q <= 1'b0;
      shut_req_q <= 1'b0;
      sleep_req_q <= 1'b0;
      hard_req_q <= 1'b0;
      is_stack_q <= 1'b0;
    end else begin
      wake_req_q <= ping_q == PT_WAKE || tone_wake_q;
      shut_req_q <= ping_q == PT_SHUTDOWN;
      sleep_req_q <= ping_q == PT_SLEEP_EXIT || tone_sleep_exit_q;
      hard_req_q <= ping_q == PT_HARD_RESET;
      if (tone_wake_q) begin
        is_stack_q <= 1'b1;
      end else if (ping_q == PT_WAKE) begin
        is_stack_q <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------------------
  // register writes and sticky status (set wins over clear)
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      multidrop_q <= RST_DEVICE_CONFIG[DCFG_MULTIDROP_BIT];
      fault_ctl_q <= 1'b0;
      gpio_mode_q <= RST_GPIO_MODE;
      spi_q <= 1'b0;
      int_status_q <= '0;
      int_mask_q <= RST_INT_MASK;
    end else begin
      if (wr_dcfg) begin
        multidrop_q <= reg_wdata_i[DCFG_MULTIDROP_BIT];
      end
      if (wr_ctl) begin
        fault_ctl_q <= reg_wdata_i[CTL_FAULT_BIT];
      end
      if (wr_gcfg) begin
        gpio_mode_q <= reg_wdata_i[15:0];
        spi_q <= reg_wdata_i[GCFG_SPI_BIT];
      end
      if (wr_imsk) begin
        int_mask_q <= reg_wdata_i[EV_WIDTH-1:0];
      end
      int_status_q <= (int_status_q & ~(wr_ists ? reg_wdata_i[EV_WIDTH-1:0] : '0)) | events;
    end
  end
  // ---------------------------------------------------------------------------
  // adc round robin: reference slot, then each gpio
  // ---------------------------------------------------------------------------
  logic [3:0] adc_ch_q; // 0 is reference, 1 to 8 gpio
  logic [7:0] slot_cnt_q;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      adc_ch_q <= 4'h0;
      slot_cnt_q <= 8'h00;
    end else if (slot_cnt_q == 8'(ADC_SLOT_CYC - 1)) begin
      slot_cnt_q <= 8'h00;
      adc_ch_q <= (adc_ch_q == 4'(ADC_CHANNELS - 1)) ? 4'h0 : adc_ch_q + 4'h1;
    end else begin
      slot_cnt_q <= slot_cnt_q + 8'h01;
    end
  end
  // ---------------------------------------------------------------------------
  // read mux and pin outputs
  // ---------------------------------------------------------------------------
  wire [31:0] rd_mux =
    (reg_addr_i == ADDR_DEVICE_CONFIG) ? {31'h0, multidrop_q} :
    (reg_addr_i == ADDR_CHAIN_CONTROL) ? {29'h0, fault_ctl_q, 2'h0} :
    (reg_addr_i == ADDR_GPIO_CONFIG) ? {15'h0, spi_q, gpio_mode_q} :
    (reg_addr_i == ADDR_STATUS) ? {29'h0, tone_busy, is_stack_q, fault_event_i} :
    (reg_addr_i == ADDR_INT_STATUS) ? {27'h0, int_status_q} :
    (reg_addr_i == ADDR_INT_MASK) ? {27'h0, int_mask_q} :
    (reg_addr_i == ADDR_ADC_CHANNEL) ? {28'h0, adc_ch_q} : 32'h0000_0000;
  // spi overrides gpio 7 to 4 modes, code 2'b11 per pin
  wire [15:0] gpio_eff = spi_q ? {8'hFF, gpio_mode_q[7:0]} : gpio_mode_q;
  // tx idles high, stack keeps transmitter quiet unless multidrop is set
  wire tx_en = !is_stack_q || multidrop_q;
  wire tx_level = tx_en ? uart_tx_data_i : 1'b1;
  wire fault_any = fault_event_i || fault_ctl_q;
  // output flops
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_q <= 32'h0000_0000;
      uart_tx_o <= 1'b1;
      uart_tx_oe_o <= 1'b0;
      upper_chain_port_o <= 1'b0;
      upper_chain_port_oe_o <= 1'b0;
      lower_chain_port_oe_o <= 1'b0;
      fault_out_n_o <= 1'b1;
      fault_out_n_oe_o <= 1'b0;
      gpio_mode_o <= RST_GPIO_MODE;
      spi_select_o <= 1'b0;
      adc_channel_o <= 4'h0;
      wake_request_o <= 1'b0;
      shutdown_request_o <= 1'b0;
      sleep_exit_request_o <= 1'b0;
      hard_reset_request_o <= 1'b0;
      is_stack_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      rdata_q <= reg_read_i ? rd_mux : 32'h0000_0000;
      uart_tx_o <= tx_level;
      uart_tx_oe_o <= !powered_down_i; // high impedance when off
      upper_chain_port_o <= tone_level_q;
      upper_chain_port_oe_o <= !multidrop_q && tone_busy;
      lower_chain_port_oe_o <= !multidrop_q && is_stack_q;
      fault_out_n_o <= 1'b0; // open drain, drive low only
      fault_out_n_oe_o <= fault_any;
      gpio_mode_o <= gpio_eff;
      spi_select_o <= spi_q;
      adc_channel_o <= adc_ch_q;
      wake_request_o <= wake_req_q;
      shutdown_request_o <= shut_req_q;
      sleep_exit_request_o <= sleep_req_q;
      hard_reset_request_o <= hard_req_q;
      is_stack_o <= is_stack_q;
      irq_o <= |(int_status_q & int_mask_q);
    end
  end
  assign reg_rdata_o = rdata_q;
endmodule

// File: pptr_top_sva.sv
/*
  checker of the ping and tone relay: assertions on the top ports only.
  assumes one clock, synchronous reset and the package couplet period.
*/
`timescale 1ns/10ps
module pptr_checker
  import pptr_pkg::*;
#(
  parameter int WAKE_TONE_LEN = WAKE_COUPLETS
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // watched inputs
  input wire logic powered_down_i,
  input wire logic fault_event_i,
  // watched outputs
  input wire logic uart_tx_o,
  input wire logic uart_tx_oe_o,
  input wire logic upper_chain_port_o,
  input wire logic upper_chain_port_oe_o,
  input wire logic fault_out_n_o,
  input wire logic fault_out_n_oe_o,
  input wire logic [15:0] gpio_mode_o,
  input wire logic spi_select_o,
  input wire logic [3:0] adc_channel_o,
  input wire logic wake_request_o,
  input wire logic shutdown_request_o,
  input wire logic sleep_exit_request_o,
  input wire logic hard_reset_request_o,
  input wire logic is_stack_o
);
  // ---------------------------------------------------------------------------
  // tone counters
  // ---------------------------------------------------------------------------
  localparam int HALF = COUPLET_CYC / 2;
  localparam int TONE_MAX = WAKE_TONE_LEN * COUPLET_CYC;
  logic [15:0] half_q; // cycles since last level change
  logic [15:0] tone_q; // cycles since tone start
  wire [3:0] req = {wake_request_o, shutdown_request_o, sleep_exit_request_o,
    hard_reset_request_o};
  // both cleared outside a tone
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || !upper_chain_port_oe_o) begin
      half_q <= 16'h0000;
      tone_q <= 16'h0000;
    end else begin
      // first cycle of a tone restarts the half period like a level change
      half_q <= ($changed(upper_chain_port_o) || $rose(upper_chain_port_oe_o)) ? 16'h0000 :
        half_q + 16'h0001;
      tone_q <= tone_q + 16'h0001;
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  property p_fault_pin;
    fault_out_n_oe_o |-> !fault_out_n_o;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin driven high");
  property p_fault_ev;
    fault_event_i |=> fault_out_n_oe_o;
  endproperty
  a_fault_ev: assert property (p_fault_ev) else $error("fault not signalled");
  property p_tx_off;
    powered_down_i |=> !uart_tx_oe_o;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx driven when off");
  property p_stack_tx;
    is_stack_o [*2] |-> uart_tx_o;
  endproperty
  a_stack_tx: assert property (p_stack_tx) else $error("stack tx not high");
  property p_no_relay;
    (shutdown_request_o || hard_reset_request_o) && !$past(upper_chain_port_oe_o)
      |-> !upper_chain_port_oe_o [*4];
  endproperty
  a_no_relay: assert property (p_no_relay) else $error("recovery ping relayed");
  property p_spi;
    spi_select_o |-> gpio_mode_o[15:8] == 8'hFF;
  endproperty
  a_spi: assert property (p_spi) else $error("spi pins keep gpio modes");
  property p_adc_step;
    !$past(reset_i) && $changed(adc_channel_o) |->
      adc_channel_o == (($past(adc_channel_o) == 4'h8) ? 4'h0 : $past(adc_channel_o) + 4'h1);
  endproperty
  a_adc_step: assert property (p_adc_step) else $error("adc order broken");
  property p_req;
    |req |-> $onehot(req) ##1 (req == 4'h0);
  endproperty
  a_req: assert property (p_req) else $error("request not single pulse");
  property p_tone_half;
    upper_chain_port_oe_o |-> half_q < HALF;
  endproperty
  a_tone_half: assert property (p_tone_half) else $error("half period too long");
  property p_tone_len;
    upper_chain_port_oe_o |-> tone_q < TONE_MAX;
  endproperty
  a_tone_len: assert property (p_tone_len) else $error("tone too long");
  c_wake: cover property (wake_request_o);
  c_stack: cover property ($rose(is_stack_o));
  c_tone: cover property (tone_q == TONE_MAX - 1);
endmodule
bind pptr_top pptr_checker #(.WAKE_TONE_LEN(WAKE_TONE_LEN)) u_chk (
  .sys_clk_i, .reset_i, .powered_down_i, .fault_event_i, .uart_tx_o, .uart_tx_oe_o,
  .upper_chain_port_o, .upper_chain_port_oe_o, .fault_out_n_o, .fault_out_n_oe_o,
  .gpio_mode_o, .spi_select_o, .adc_channel_o, .wake_request_o, .shutdown_request_o,
  .sleep_exit_request_o, .hard_reset_request_o, .is_stack_o
);

// File: pptr_far_model.sv
/*
  far side model: host pinging the receive line, lower neighbour sending
  tones on the lower chain port. assumes the bench calls its tasks.
*/
`timescale 1ns/10ps
module pptr_far_model
  import pptr_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // pins toward the block
  output logic rx_o,
  output logic chain_o
);
  // ---------------------------------------------------------------------------
  // idle levels and tasks
  // ---------------------------------------------------------------------------
  initial begin
    rx_o = 1'b1; // pulled up, idle high
    chain_o = 1'b0; // still between tones
  end
  // high-low-high ping of low_cyc cycles, receive line only
  task automatic ping(input int low_cyc);
    @(posedge sys_clk_i);
    rx_o <= 1'b0;
    repeat (low_cyc) @(posedge sys_clk_i);
    rx_o <= 1'b1;
  endtask
  // n couplets, level change every half period
  task automatic tone(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge sys_clk_i);
      chain_o <= ~chain_o;
      repeat (COUPLET_CYC / 2 - 1) @(posedge sys_clk_i);
    end
  endtask
endmodule

// File: test_power_ping_tone_relay.sv
/*
  bench of the ping and tone relay: register tasks, pings and tones from
  the far model, queued expectations checked by a monitor process.
  assumes package tone lengths and short ping windows set below.
*/
`timescale 1ns/10ps
module test_power_ping_tone_relay;
  import pptr_pkg::*;
  // ---------------------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_write_i = 1'b0, reg_read_i = 1'b0, rd_seen = 1'b0;
  logic uart_tx_data_i = 1'b1, powered_down_i = 1'b0, fault_event_i = 1'b0, tx_last = 1'b1;
  logic [31:0] reg_rdata_o;
  logic [15:0] gpio_mode_o, rnd;
  logic [3:0] adc_channel_o;
  logic uart_rx_i, lower_chain_port_i, uart_tx_o, uart_tx_oe_o, upper_chain_port_o;
  logic upper_chain_port_oe_o, lower_chain_port_oe_o, fault_out_n_o, fault_out_n_oe_o;
  logic spi_select_o, wake_request_o, shutdown_request_o, sleep_exit_request_o;
  logic hard_reset_request_o, is_stack_o, irq_o;
  int fail_count = 0, total_checks = 0, ev_cnt = 0, cyc = 0, n;
  integer seed = 32'h134B0E41;
  logic [31:0] rd_q[$]; // expected read data
  logic [3:0] ev_q[$]; // expected request pulses
  wire [3:0] ev = {wake_request_o, shutdown_request_o, sleep_exit_request_o,
    hard_reset_request_o};
  pptr_top #(.SLEEP_EXIT_MIN(20), .WAKE_MIN(40), .SHUTDOWN_MIN(80), .HARD_RESET_MIN(160)) uut (
    .sys_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
    .reg_rdata_o, .uart_rx_i, .uart_tx_o, .uart_tx_oe_o, .uart_tx_data_i, .powered_down_i,
    .lower_chain_port_i, .upper_chain_port_o, .upper_chain_port_oe_o,
    .lower_chain_port_oe_o, .fault_event_i, .fault_out_n_o, .fault_out_n_oe_o,
    .gpio_mode_o, .spi_select_o, .adc_channel_o, .wake_request_o, .shutdown_request_o,
    .sleep_exit_request_o, .hard_reset_request_o, .is_stack_o, .irq_o
  );
  pptr_far_model far (.sys_clk_i, .rx_o(uart_rx_i), .chain_o(lower_chain_port_i));
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_write_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    rd_q.push_back(e);
    @(posedge sys_clk_i);
    reg_read_i <= 1'b0;
  endtask
  // ping with its expected request code, zero for none
  task automatic pg(input int len, input logic [3:0] e);
    if (e != 4'h0) ev_q.push_back(e);
    far.ping(len);
  endtask
  // length of the next tone on the upper port
  task automatic tone_len(input int exp);
    int k = 0;
    int h = 0;
    while (upper_chain_port_oe_o !== 1'b1 && k < 1500) begin
      @(posedge sys_clk_i);
      k++;
    end
    while (upper_chain_port_oe_o === 1'b1 && h < 4000) begin
      @(posedge sys_clk_i);
      h++;
    end
    chk(h, exp);
  endtask
  task automatic quiet(input int k);
    int h = 0;
    repeat (k) begin
      @(posedge sys_clk_i);
      if (upper_chain_port_oe_o !== 1'b0) h++;
    end
    chk(h, 0);
  endtask
  // ---------------------------------------------------------------------------
  // monitor: read data, request pulses, random tx level, hang limit
  // ---------------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    rd_seen <= reg_read_i;
    uart_tx_data_i <= 1'($random(seed));
    tx_last <= uart_tx_data_i; // level the design took at this edge
    cyc <= cyc + 1;
    if (rd_seen) chk(reg_rdata_o, rd_q.pop_front());
    if (|ev) begin
      ev_cnt++;
      if (ev_q.size() > 0) chk({28'h0, ev}, {28'h0, ev_q.pop_front()});
    end
    if (cyc == 40000) begin
      fail_count++;
      close_out();
    end
  end
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    wt(2);
    chk(gpio_mode_o, 16'h0000);
    chk(uart_tx_o, tx_last);
    chk(fault_out_n_oe_o, 1'b0);
    rd(ADDR_GPIO_CONFIG, 32'h0);
    rd(ADDR_DEVICE_CONFIG, 32'h0);
    rd(ADDR_INT_MASK, 32'h0);
    rd(8'hFC, 32'h0);
    pg(30, 4'h2);
    tone_len(SLEEP_EXIT_COUPLETS * COUPLET_CYC);
    pg(60, 4'h8);
    tone_len(WAKE_COUPLETS * COUPLET_CYC);
    pg(120, 4'h4);
    quiet(300);
    pg(220, 4'h1);
    quiet(300);
    n = ev_cnt;
    pg(8, 4'h0);
    wt(50);
    chk(ev_cnt, n);
    rd(ADDR_INT_STATUS, 32'h1F);
    chk(irq_o, 1'b0); // mask bits enable, all off after reset
    wr(ADDR_INT_MASK, 32'h1F);
    wt(2);
    chk(irq_o, 1'b1);
    wr(ADDR_INT_STATUS, 32'h1F);
    wt(2);
    chk(irq_o, 1'b0);
    wr(ADDR_INT_MASK, 32'h0);
    rd(ADDR_INT_STATUS, 32'h0);
    wr(ADDR_CHAIN_CONTROL, 32'h1);
    tone_len(WAKE_COUPLETS * COUPLET_CYC);
    wr(ADDR_CHAIN_CONTROL, 32'h2);
    tone_len(SLEEP_EXIT_COUPLETS * COUPLET_CYC);
    wr(ADDR_DEVICE_CONFIG, 32'h1);
    pg(60, 4'h8);
    quiet(300);
    chk(lower_chain_port_oe_o, 1'b0);
    wr(ADDR_DEVICE_CONFIG, 32'h0);
    ev_q.push_back(4'h8);
    far.tone(WAKE_COUPLETS);
    tone_len(WAKE_COUPLETS * COUPLET_CYC);
    chk(is_stack_o, 1'b1);
    chk(lower_chain_port_oe_o, 1'b1);
    chk(uart_tx_o, 1'b1);
    rd(ADDR_STATUS, 32'h2);
    pg(60, 4'h8);
    tone_len(WAKE_COUPLETS * COUPLET_CYC);
    chk(is_stack_o, 1'b0);
    fault_event_i <= 1'b1;
    wt(3);
    chk(fault_out_n_oe_o, 1'b1);
    chk(fault_out_n_o, 1'b0);
    rd(ADDR_STATUS, 32'h1);
    fault_event_i <= 1'b0;
    wt(3);
    chk(fault_out_n_oe_o, 1'b0);
    wr(ADDR_CHAIN_CONTROL, 32'h4);
    wt(3);
    chk(fault_out_n_oe_o, 1'b1);
    wr(ADDR_CHAIN_CONTROL, 32'h0);
    rnd = 16'($random(seed));
    wr(ADDR_GPIO_CONFIG, {16'h0000, rnd});
    wt(2);
    chk(gpio_mode_o, rnd);
    wr(ADDR_GPIO_CONFIG, {15'h0000, 1'b1, rnd});
    wt(2);
    chk(gpio_mode_o, {8'hFF, rnd[7:0]});
    chk(spi_select_o, 1'b1);
    rd(ADDR_GPIO_CONFIG, {15'h0000, 1'b1, rnd});
    powered_down_i <= 1'b1;
    wt(2);
    chk(uart_tx_oe_o, 1'b0);
    powered_down_i <= 1'b0;
    wt(2);
    chk(uart_tx_oe_o, 1'b1);
    wt(4);
    close_out();
  end
endmodule
